// [design/rdo_params.svh]
// timing and width constants for the decoder output sequencer
`ifndef RDO_PARAMS_SVH
`define RDO_PARAMS_SVH
// ---------------------------------------------------------------
// clock scaling
// ---------------------------------------------------------------
`define OSC_MHZ 1
`define CLK_MHZ 100
`define CYC_PER_OSC (`CLK_MHZ / `OSC_MHZ)
// ---------------------------------------------------------------
// widths
// ---------------------------------------------------------------
`define CNT_W 26
`define PER_W 19
`define GL_W 11
`define BTN_W 3
// ---------------------------------------------------------------
// times in microseconds of the nominal oscillator
// ---------------------------------------------------------------
`define PER_MIN_US 400
`define PER_MAX_US 3600
`define FAST_PER_US 1000
`define SLOW_PER_US 2000
`define TOS_MIN_US 122000
`define FN_US 530000
`define DLY_US 500000
`define REP1_US 500000
`define REP2_US 49000
`define GAP_FAST_US 160000
`define GAP_TYP_US 260000
`define GAP_SLOW_US 610000
`define LRN_RST_US 20000
`define LRN_REP_US 50000
`define REFRESH_US 50000
`define GLITCH_US 10
`define GLITCH_CYC (`GLITCH_US * `CYC_PER_OSC)
// ---------------------------------------------------------------
// rate classes and sync bit positions
// ---------------------------------------------------------------
`define RATE_TYP 2'h0
`define RATE_FAST 2'h1
`define RATE_SLOW 2'h2
`define SY_DATA 0
`define SY_RST 1
`define SY_LRN 2
`endif

// [design/rdo_pkg.sv]
// types of the decoder output sequencer
`include "rdo_params.svh"
package rdo_pkg;
  typedef enum logic [1:0] {PH_IDLE, PH_WAIT} phase_e;
  typedef enum logic [1:0] {RP_IDLE, RP_ON, RP_GAP} rep_e;
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic data_q;
    logic lrn_q;
    logic [`PER_W-1:0] per_cnt;
    logic per_err;
    logic [1:0] rate;
    phase_e phase;
    logic [`CNT_W-1:0] tos_cnt;
    logic [`BTN_W-1:0] btn;
    logic priv;
    logic [`CNT_W-1:0] fn_cnt;
    logic [`BTN_W-1:0] fn;
    logic prv;
    logic [`CNT_W-1:0] dly_cnt;
    logic dly;
    rep_e rep;
    logic [`CNT_W-1:0] rep_cnt;
    logic rep_pend;
    logic tog;
    logic [`CNT_W-1:0] ref_cnt;
    logic [`GL_W-1:0] gl_cnt;
    logic learn;
    logic [1:0] n_ok;
    logic [1:0] n_bad;
    logic armed;
    logic [`CNT_W-1:0] lrn_cnt;
    logic [`CNT_W-1:0] rh_cnt;
    logic o_tog;
    logic o_rep;
    logic o_dly;
  } core_s;
endpackage

// [design/remote_decoder_output_timing.sv]
// output sequencing and learn-mode entry of the rolling-code decoder
//
// Overview of operation
// - all durations are cycle counts scaled from the nominal 1 MHz oscillator.
// - accept input bit periods between 0.4 ms and 3.6 ms.
// - outputs start 122 to 160 ms after a validated transmission.
// - valid-signal pulse lasts 500 ms first, 49 ms on repeats.
// - gap between valid-signal pulses 160, 260 or 610 ms by input rate.
// - latched toggle output inverts on each first pulsed output activation.
// - latched toggle output may dip low up to 10 us, every 50 ms.
// - valid and delayed outputs may blip high up to 10 us, every 50 ms.
// - reset and learn low, learn released 20 ms after reset enters learn.
// - learn held low while valid output high over 50 ms, with function, privileged and delayed outputs low, enters learn.
// - learn mode ends after two valid or two invalid transmissions.
// - continued valid reception gives about 50 ms valid-signal pulses.
// - privileged transmitter also raises the privileged flag output.
// - button code selects which function outputs fire.
`timescale 1ns/1ps
`include "rdo_params.svh"
module remote_decoder_output_timing #(
  parameter int unsigned PER_MIN_CYC = `PER_MIN_US * `CYC_PER_OSC,
  parameter int unsigned PER_MAX_CYC = `PER_MAX_US * `CYC_PER_OSC,
  parameter int unsigned FAST_PER_CYC = `FAST_PER_US * `CYC_PER_OSC,
  parameter int unsigned SLOW_PER_CYC = `SLOW_PER_US * `CYC_PER_OSC,
  parameter int unsigned TOS_CYC = `TOS_MIN_US * `CYC_PER_OSC,
  parameter int unsigned FN_CYC = `FN_US * `CYC_PER_OSC,
  parameter int unsigned DLY_CYC = `DLY_US * `CYC_PER_OSC,
  parameter int unsigned REP1_CYC = `REP1_US * `CYC_PER_OSC,
  parameter int unsigned REP2_CYC = `REP2_US * `CYC_PER_OSC,
  parameter int unsigned GAP_FAST_CYC = `GAP_FAST_US * `CYC_PER_OSC,
  parameter int unsigned GAP_TYP_CYC = `GAP_TYP_US * `CYC_PER_OSC,
  parameter int unsigned GAP_SLOW_CYC = `GAP_SLOW_US * `CYC_PER_OSC,
  parameter int unsigned LRN_RST_CYC = `LRN_RST_US * `CYC_PER_OSC,
  parameter int unsigned LRN_REP_CYC = `LRN_REP_US * `CYC_PER_OSC,
  parameter int unsigned REFRESH_CYC = `REFRESH_US * `CYC_PER_OSC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic data_in_i,
  input wire logic reset_pin_n_i,
  input wire logic learn_sel_n_i,
  input wire logic frame_done_i,
  input wire logic frame_ok_i,
  input wire logic [`BTN_W-1:0] button_i,
  input wire logic privileged_i,
  output logic first_pulsed_output_o,
  output logic second_pulsed_output_o,
  output logic third_pulsed_output_o,
  output logic latched_toggle_output_o,
  output logic valid_signal_o,
  output logic delayed_function_o,
  output logic privileged_flag_o,
  output logic learn_mode_o,
  output logic bit_period_err_o
);
  import rdo_pkg::*;

  core_s st;
  core_s next_st;
  logic rise;
  logic act;
  logic glitch;
  logic fn_busy;
  logic [`CNT_W-1:0] gap;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.s1 = {learn_sel_n_i, reset_pin_n_i, data_in_i};
    next_st.s2 = st.s1;
    next_st.data_q = st.s2[`SY_DATA];
    next_st.lrn_q = st.s2[`SY_LRN];
    next_st.per_err = 1'b0;
    rise = st.s2[`SY_DATA] & ~st.data_q;
    act = (st.phase == PH_WAIT) && (st.tos_cnt == '0);
    glitch = st.gl_cnt != '0;
    fn_busy = (st.fn != '0) || st.prv;
    unique case (st.rate)
      `RATE_FAST: gap = `CNT_W'(GAP_FAST_CYC - 1);
      `RATE_SLOW: gap = `CNT_W'(GAP_SLOW_CYC - 1);
      default: gap = `CNT_W'(GAP_TYP_CYC - 1);
    endcase

    // bit period measured rising edge to rising edge
    if (rise) begin
      // the edge cycle itself counts, so a legal minimum period is not refused
      next_st.per_cnt = `PER_W'(1);
      if (st.per_cnt < `PER_W'(PER_MIN_CYC) || st.per_cnt > `PER_W'(PER_MAX_CYC)) begin
        next_st.per_err = 1'b1;
      end else if (st.per_cnt < `PER_W'(FAST_PER_CYC)) begin
        next_st.rate = `RATE_FAST;
      end else if (st.per_cnt > `PER_W'(SLOW_PER_CYC)) begin
        next_st.rate = `RATE_SLOW;
      end else begin
        next_st.rate = `RATE_TYP;
      end
    end else if (st.per_cnt != '1) begin
      next_st.per_cnt = st.per_cnt + `PER_W'(1);
    end

    // transmission results
    if (frame_done_i && st.learn) begin
      if (frame_ok_i) begin
        next_st.n_ok = st.n_ok + 2'h1;
        if (st.n_ok == 2'h1) begin
          next_st.learn = 1'b0;
        end
      end else begin
        next_st.n_bad = st.n_bad + 2'h1;
        if (st.n_bad == 2'h1) begin
          next_st.learn = 1'b0;
        end
      end
    end
    // an invalid frame must not stall the running delay
    if (frame_done_i && frame_ok_i && !st.learn) begin
      next_st.phase = PH_WAIT;
      next_st.tos_cnt = `CNT_W'(TOS_CYC - 1);
      next_st.btn = button_i;
      next_st.priv = privileged_i;
    end else if (st.phase == PH_WAIT) begin
      if (act) begin
        next_st.phase = PH_IDLE;
      end else begin
        next_st.tos_cnt = st.tos_cnt - `CNT_W'(1);
      end
    end

    // function and privileged outputs
    if (fn_busy) begin
      if (st.fn_cnt == '0) begin
        next_st.fn = '0;
        next_st.prv = 1'b0;
      end else begin
        next_st.fn_cnt = st.fn_cnt - `CNT_W'(1);
      end
    end
    if (st.dly) begin
      if (st.dly_cnt == '0) begin
        next_st.dly = 1'b0;
      end else begin
        next_st.dly_cnt = st.dly_cnt - `CNT_W'(1);
      end
    end

    // valid-signal pulse train
    unique case (st.rep)
      RP_ON: begin
        if (st.rep_cnt == '0) begin
          next_st.rep = RP_GAP;
          next_st.rep_cnt = gap;
        end else begin
          next_st.rep_cnt = st.rep_cnt - `CNT_W'(1);
        end
      end
      RP_GAP: begin
        if (st.rep_cnt != '0) begin
          next_st.rep_cnt = st.rep_cnt - `CNT_W'(1);
        end else if (st.rep_pend) begin
          next_st.rep = RP_ON;
          next_st.rep_cnt = `CNT_W'(REP2_CYC - 1);
          next_st.rep_pend = 1'b0;
        end else begin
          next_st.rep = RP_IDLE;
        end
      end
      default: ;
    endcase

    // activation once the output delay has run out
    if (act) begin
      next_st.fn = st.btn;
      next_st.prv = st.priv;
      next_st.fn_cnt = `CNT_W'(FN_CYC - 1);
      if (st.btn[0]) begin
        next_st.tog = ~st.tog;
      end
      if (st.rep == RP_IDLE) begin
        next_st.rep = RP_ON;
        next_st.rep_cnt = `CNT_W'(REP1_CYC - 1);
      end else begin
        // held button: repeat pulse later, delayed output now
        next_st.rep_pend = 1'b1;
        next_st.dly = 1'b1;
        next_st.dly_cnt = `CNT_W'(DLY_CYC - 1);
      end
    end

    // learn entry by reset and learn pins
    if (!st.s2[`SY_RST] && !st.s2[`SY_LRN]) begin
      next_st.armed = 1'b1;
      next_st.lrn_cnt = '0;
    end else if (st.armed) begin
      if (st.s2[`SY_LRN] && !st.lrn_q) begin
        next_st.armed = 1'b0;
        if (st.lrn_cnt >= `CNT_W'(LRN_RST_CYC)) begin
          next_st.learn = 1'b1;
          next_st.n_ok = 2'h0;
          next_st.n_bad = 2'h0;
        end
      end else if (st.lrn_cnt != '1) begin
        next_st.lrn_cnt = st.lrn_cnt + `CNT_W'(1);
      end
    end

    // learn entry by holding learn over a quiet valid pulse
    if (!st.s2[`SY_LRN] && st.rep == RP_ON && !fn_busy && !st.dly) begin
      if (st.rh_cnt == `CNT_W'(LRN_REP_CYC)) begin
        next_st.learn = 1'b1;
        next_st.n_ok = 2'h0;
        next_st.n_bad = 2'h0;
      end else begin
        next_st.rh_cnt = st.rh_cnt + `CNT_W'(1);
      end
    end else begin
      next_st.rh_cnt = '0;
    end

    // periodic output refresh: short blip, lasting the full 10 us limit
    if (st.ref_cnt == '0) begin
      next_st.ref_cnt = `CNT_W'(REFRESH_CYC - 1);
      next_st.gl_cnt = `GL_W'(`GLITCH_CYC);
    end else begin
      next_st.ref_cnt = st.ref_cnt - `CNT_W'(1);
      if (glitch) begin
        next_st.gl_cnt = st.gl_cnt - `GL_W'(1);
      end
    end
    next_st.o_tog = next_st.tog & ~(next_st.gl_cnt != '0);
    next_st.o_rep = (next_st.rep == RP_ON) | (next_st.gl_cnt != '0);
    next_st.o_dly = next_st.dly | (next_st.gl_cnt != '0);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign first_pulsed_output_o = st.fn[0];
  assign second_pulsed_output_o = st.fn[1];
  assign third_pulsed_output_o = st.fn[2];
  assign latched_toggle_output_o = st.o_tog;
  assign valid_signal_o = st.o_rep;
  assign delayed_function_o = st.o_dly;
  assign privileged_flag_o = st.prv;
  assign learn_mode_o = st.learn;
  assign bit_period_err_o = st.per_err;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // cycles since the last accepted transmission
  logic [`CNT_W-1:0] hlp_wait;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hlp_wait <= '0;
    end else if (frame_done_i && frame_ok_i && !st.learn) begin
      hlp_wait <= `CNT_W'(1);
    end else if (hlp_wait != '1) begin
      hlp_wait <= hlp_wait + `CNT_W'(1);
    end
  end

  a_output_delay: assert property (act |-> hlp_wait == `CNT_W'(TOS_CYC))
    else $error("activation not at the output delay");
  a_toggle_flip: assert property (act && st.btn[0] |=> st.tog != $past(st.tog))
    else $error("toggle did not invert");
  a_button_map: assert property (act |=> st.fn == $past(st.btn) && st.prv == $past(st.priv))
    else $error("function outputs differ from button code");
  a_first_pulse: assert property (act && st.rep == RP_IDLE |=> st.rep_cnt == `CNT_W'(REP1_CYC - 1))
    else $error("first valid pulse length wrong");
  a_fn_end: assert property (fn_busy && st.fn_cnt == '0 |=> st.fn == '0 && !st.prv)
    else $error("function outputs did not end");
  a_learn_two_ok: assert property (st.learn && frame_done_i && frame_ok_i && st.n_ok == 2'h1
      |=> !st.learn)
    else $error("learn mode kept after two valid frames");
  a_learn_two_bad: assert property (st.learn && frame_done_i && !frame_ok_i && st.n_bad == 2'h1
      |=> !st.learn)
    else $error("learn mode kept after two invalid frames");
  a_glitch_short: assert property (st.gl_cnt <= `GL_W'(`GLITCH_CYC))
    else $error("refresh blip too long");
  a_period_err: assert property (rise && st.per_cnt < `PER_W'(PER_MIN_CYC) |=> bit_period_err_o)
    else $error("short bit period not flagged");
  a_reset_learn: assert property (st.armed && st.s2[`SY_RST] && st.s2[`SY_LRN] && !st.lrn_q
      && st.lrn_cnt >= `CNT_W'(LRN_RST_CYC) |=> st.learn)
    else $error("pin procedure did not enter learn mode");

  c_activation: cover property (act);
  c_repeat_pulse: cover property (st.rep == RP_GAP && st.rep_pend && st.rep_cnt == '0);
  c_learn_enter: cover property (!st.learn ##1 st.learn);
  c_learn_exit: cover property (st.learn ##1 !st.learn);
endmodule

// [sim/rdo_rx_model.sv]
// receiver model driving square-wave bit edges into the decoder
`timescale 1ns/1ps
module rdo_rx_model (
  input wire logic core_clk_i,
  output logic data_o
);
  // ---------------------------------------------------------------
  // bit bursts
  // ---------------------------------------------------------------
  // the receiver drives its output, so the line rests low between bursts
  initial data_o = 1'b0;
  // one rising edge every period cycles; callers keep periods legal unless testing errors
  task automatic send_bits(input int period, input int count);
    for (int i = 0; i < count; i++) begin
      @(posedge core_clk_i);
      data_o <= 1'b1;
      repeat (period / 2) @(posedge core_clk_i);
      data_o <= 1'b0;
      repeat (period - period / 2 - 1) @(posedge core_clk_i);
    end
  endtask
endmodule

// [sim/remote_decoder_output_timing_bench.sv]
// self-checking bench for the decoder output sequencer
`timescale 1ns/1ps
`include "rdo_params.svh"
`define CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin errors++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module remote_decoder_output_timing_bench;
  import rdo_pkg::*;
  // ---------------------------------------------------------------
  // shortened counts, ordering kept only within the periods, the gaps and the pulse lengths
  // ---------------------------------------------------------------
  localparam int TOS = 200;
  localparam int FN = 300;
  localparam int DLY = 250;
  localparam int REP1 = 250;
  localparam int REP2 = 40;
  localparam int LRN = 50;
  localparam int PMIN = 40, PMAX = 360, PFAST = 100, PSLOW = 200;
  localparam int GFAST = 60, GTYP = 100, GSLOW = 150, LRST = 50, REFR = 8000;
  localparam int F1 = 0, F2 = 1, TG = 3, VS = 4, DF = 5, PF = 6, LM = 7;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic reset_pin_n_i = 1'b1;
  logic learn_sel_n_i = 1'b1;
  logic frame_done_i = 1'b0;
  logic frame_ok_i = 1'b0;
  logic [`BTN_W-1:0] button_i = '0;
  logic privileged_i = 1'b0;
  wire logic data_in;
  wire logic [8:0] outs;
  int errors = 0;
  int compares = 0;
  int err_seen = 0;
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (outs[8] === 1'b1) err_seen++;
  rdo_rx_model rx (.core_clk_i(core_clk_i), .data_o(data_in));
  remote_decoder_output_timing #(.PER_MIN_CYC(PMIN), .PER_MAX_CYC(PMAX), .FAST_PER_CYC(PFAST),
    .SLOW_PER_CYC(PSLOW), .TOS_CYC(TOS), .FN_CYC(FN), .DLY_CYC(DLY), .REP1_CYC(REP1),
    .REP2_CYC(REP2), .GAP_FAST_CYC(GFAST), .GAP_TYP_CYC(GTYP), .GAP_SLOW_CYC(GSLOW),
    .LRN_RST_CYC(LRST), .LRN_REP_CYC(LRN), .REFRESH_CYC(REFR)) DUT (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .data_in_i(data_in),
    .reset_pin_n_i(reset_pin_n_i), .learn_sel_n_i(learn_sel_n_i),
    .frame_done_i(frame_done_i), .frame_ok_i(frame_ok_i), .button_i(button_i),
    .privileged_i(privileged_i), .first_pulsed_output_o(outs[0]),
    .second_pulsed_output_o(outs[1]), .third_pulsed_output_o(outs[2]),
    .latched_toggle_output_o(outs[3]), .valid_signal_o(outs[4]),
    .delayed_function_o(outs[5]), .privileged_flag_o(outs[6]), .learn_mode_o(outs[7]),
    .bit_period_err_o(outs[8]));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic results;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  function automatic logic inr(input int n, input int lo, input int hi);
    return (n >= lo && n <= hi);
  endfunction
  // counts edges until the output reaches the level; a spent bound ends the run
  task automatic wait_sig(input int idx, input logic lvl, input int bound, output int n);
    n = 0;
    while (outs[idx] !== lvl && n < bound) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    if (outs[idx] !== lvl) begin
      errors++;
      $display("Error wait on output %0d expected %0b seen %0b", idx, lvl, outs[idx]);
      results();
    end
  endtask
  task automatic frame(input logic ok, input logic [`BTN_W-1:0] btn, input logic prv);
    @(posedge core_clk_i);
    frame_done_i <= 1'b1;
    frame_ok_i <= ok;
    button_i <= btn;
    privileged_i <= prv;
    @(posedge core_clk_i);
    frame_done_i <= 1'b0;
  endtask
  // waits past the refresh blip that follows every release
  task automatic do_reset;
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (1100) @(posedge core_clk_i);
  endtask
  task automatic learn_pins(input int w);
    @(posedge core_clk_i);
    reset_pin_n_i <= 1'b0;
    learn_sel_n_i <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    reset_pin_n_i <= 1'b1;
    repeat (w) @(posedge core_clk_i);
    learn_sel_n_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    #1;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_blip;
    int n;
    #1;
    `CHK("outputs in reset", 9'h000, outs)
    // refresh blip already shows at the first edge after release
    @(posedge core_clk_i);
    #1;
    `CHK("outputs after release", 9'h030, outs)
    wait_sig(VS, 1'b1, 5, n);
    wait_sig(VS, 1'b0, 2100, n);
    `CHK("blip width", 1'b1, inr(n, 999, 1001))
    $display("test blip done");
  endtask
  task automatic t_activate;
    int n;
    int m;
    frame(1'b1, 3'h5, 1'b1);
    wait_sig(F1, 1'b1, TOS + 10, n);
    `CHK("delay to outputs", TOS, n)
    `CHK("output set", 7'h5D, outs[6:0])
    wait_sig(VS, 1'b0, REP1 + 10, m);
    `CHK("first valid pulse", 1'b1, inr(m, REP1 - 1, REP1 + 1))
    wait_sig(F1, 1'b0, FN, n);
    `CHK("function width", 1'b1, inr(n + m, FN - 1, FN + 1))
    `CHK("flag ends with function", 1'b0, outs[PF])
    `CHK("toggle holds", 1'b1, outs[TG])
    $display("test activate done");
  endtask
  task automatic t_repeat;
    int per[3] = '{80, 150, 300};
    int gap[3] = '{GFAST, GTYP, GSLOW};
    int n;
    realtime t;
    for (int i = 0; i < 3; i++) begin
      do_reset();
      rx.send_bits(per[i], 6);
      frame(1'b1, 3'h1, 1'b0);
      wait_sig(F1, 1'b1, TOS + 10, n);
      frame(1'b1, 3'h1, 1'b0);
      wait_sig(DF, 1'b1, TOS + 10, n);
      t = $realtime;
      `CHK("toggle after two", 1'b0, outs[TG])
      wait_sig(VS, 1'b0, REP1, n);
      wait_sig(VS, 1'b1, 200, n);
      `CHK("pulse gap", 1'b1, inr(n, gap[i] - 1, gap[i] + 1))
      wait_sig(VS, 1'b0, REP2 + 10, n);
      `CHK("repeat pulse", 1'b1, inr(n, REP2 - 1, REP2 + 1))
      wait_sig(DF, 1'b0, DLY, n);
      `CHK("delayed width", 1'b1, inr(int'(($realtime - t) / 10), DLY - 1, DLY + 1))
    end
    $display("test repeat done");
  endtask
  task automatic t_bits;
    int per[4] = '{PMIN - 1, PMIN, PMAX, PMAX + 1};
    for (int i = 0; i < 4; i++) begin
      repeat (500) @(posedge core_clk_i);
      err_seen = 0;
      rx.send_bits(per[i], 4);
      repeat (400) @(posedge core_clk_i);
      `CHK("period errors", (per[i] < PMIN || per[i] > PMAX) ? 4 : 1, err_seen)
    end
    $display("test bits done");
  endtask
  task automatic t_refuse;
    int n;
    do_reset();
    frame(1'b0, 3'h4, 1'b0);
    repeat (TOS + 20) @(posedge core_clk_i);
    #1;
    `CHK("invalid frame outputs", 3'h0, outs[2:0])
    frame(1'b1, 3'h1, 1'b0);
    repeat (100) @(posedge core_clk_i);
    frame(1'b1, 3'h2, 1'b0);
    // an invalid frame inside the delay neither stalls nor restarts it
    frame(1'b0, 3'h4, 1'b0);
    wait_sig(F2, 1'b1, TOS + 10, n);
    `CHK("restarted delay", TOS - 2, n)
    `CHK("dropped frame", 3'h2, outs[2:0])
    $display("test refuse done");
  endtask
  task automatic t_learn;
    do_reset();
    learn_pins(30);
    `CHK("early learn release", 1'b0, outs[LM])
    learn_pins(60);
    `CHK("learn by reset pin", 1'b1, outs[LM])
    for (int i = 0; i < 2; i++) begin
      frame(1'b0, 3'h1, 1'b0);
      repeat (5) @(posedge core_clk_i);
      #1;
      `CHK("learn after bad frames", i == 0, outs[LM])
    end
    learn_pins(60);
    frame(1'b1, 3'h1, 1'b0);
    repeat (TOS + 20) @(posedge core_clk_i);
    #1;
    `CHK("learn frame quiet", 8'h80, outs[LM:F1])
    frame(1'b1, 3'h1, 1'b0);
    repeat (5) @(posedge core_clk_i);
    #1;
    `CHK("learn after good frames", 1'b0, outs[LM])
    $display("test learn done");
  endtask
  task automatic t_learn_rep;
    int n;
    for (int b = 1; b >= 0; b--) begin
      do_reset();
      @(posedge core_clk_i);
      learn_sel_n_i <= 1'b0;
      frame(1'b1, b[2:0], 1'b0);
      wait_sig(VS, 1'b1, TOS + 10, n);
      if (b == 1) begin
        repeat (LRN + 20) @(posedge core_clk_i);
        #1;
        `CHK("learn with function high", 1'b0, outs[LM])
      end else begin
        wait_sig(LM, 1'b1, LRN + 20, n);
        `CHK("learn by valid pulse", 1'b1, inr(n, LRN + 1, LRN + 4))
      end
      @(posedge core_clk_i);
      learn_sel_n_i <= 1'b1;
    end
    $display("test learn_rep done");
  endtask
  task automatic t_dip;
    int n;
    do_reset();
    frame(1'b1, 3'h1, 1'b0);
    wait_sig(TG, 1'b1, TOS + 10, n);
    wait_sig(TG, 1'b0, REFR, n);
    wait_sig(TG, 1'b1, 6000, n);
    `CHK("toggle dip width", 1'b1, inr(n, 999, 1001))
    $display("test dip done");
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_blip();
    t_activate();
    t_repeat();
    t_bits();
    t_refuse();
    t_learn();
    t_learn_rep();
    t_dip();
    results();
  end
endmodule
